// ==== bench/fsr_host_model.sv ====
`timescale 1ns/1ps

// Host side: runs write frames and captures the readback word
module fsr_host_model (
  // Clock
  input  wire logic clk,
  // Serial readback
  input  wire logic sdo,
  input  wire logic sdo_oe,
  // Frame events
  output logic      frame_start,
  output logic      shift_tick,
  output logic      frame_valid,
  output logic      crc_error
);
  // Idle levels
  initial
  begin
    frame_start = 1'b0;
    shift_tick  = 1'b0;
    frame_valid = 1'b0;
    crc_error   = 1'b0;
  end

  // Voltage code to volts, code zero is 0 V
  function automatic real code_volts(input logic [7:0] code);
    return (2.5 / 256.0) * code;
  endfunction

  // Temperature code to degrees
  function automatic real code_degc(input logic [7:0] code);
    return 312.0 - 1.559 * code;
  endfunction

  // One frame: start, sixteen bit captures, then signal CRC error or valid frame
  task automatic do_frame(input logic bad, output logic [15:0] word, output int n_oe);
    int i;
    word = 16'h0000;
    n_oe = 0;
    @(posedge clk);
    #1 frame_start = 1'b1;
    @(posedge clk);
    #1 frame_start = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      word[i] = sdo;
      if (sdo_oe === 1'b1)
        n_oe++;
      shift_tick = 1'b1;
      @(posedge clk);
      #1;
    end
    shift_tick  = 1'b0;
    crc_error   = bad;
    frame_valid = ~bad;
    @(posedge clk);
    #1 crc_error = 1'b0;
    frame_valid = 1'b0;
  endtask
endmodule

// ==== bench/test_fault_status_register.sv ====
`timescale 1ns/1ps

module test_fault_status_register;
  logic                 clk;
  logic                 rst;
  logic                 ce;
  logic                 afd;
  logic                 sel_temp;
  logic                 suppress;
  logic                 wd_en;
  logic [7:0]           tmo;
  logic                 f_start;
  logic                 tick;
  logic                 f_valid;
  logic                 crc;
  fsr_pkg::fsr_comp_t   comp;
  logic                 adc_done;
  logic [7:0]           s_code;
  logic [7:0]           t_code;
  logic                 dir_up;
  fsr_pkg::fsr_status_t fs;
  logic                 alert;
  logic                 force_o;
  logic                 up_o;
  logic                 sdo;
  logic                 sdo_oe;
  logic [15:0]          fsw;
  int                   n_fail;
  int                   checks_done;
  logic [15:0]          w;
  int                   n;

  assign fsw = fs;

  // Device under test with a short timeout width
  fsr_fault_status #(.WD_W(8)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .alarm_force_disable(afd),
    .adc_select_temp(sel_temp), .readback_suppress(suppress),
    .watchdog_enable(wd_en), .timeout_cycles(tmo), .frame_start(f_start),
    .shift_tick(tick), .frame_valid(f_valid), .crc_error(crc), .comp(comp),
    .adc_done(adc_done), .adc_sense_code(s_code), .adc_temp_code(t_code),
    .alarm_dir_up(dir_up), .fault_status(fs), .fault_alert(alert),
    .alarm_force(force_o), .alarm_upscale(up_o), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  // Host partner
  fsr_host_model i_host (
    .clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .frame_start(f_start),
    .shift_tick(tick), .frame_valid(f_valid), .crc_error(crc)
  );

  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Comparator flags, alert mapping and temperature hysteresis
  task automatic t_flags();
    int cb[6] = '{7, 6, 5, 3, 1, 0};
    int sb[6] = '{fsr_pkg::FSR_BIT_I_HIGH, fsr_pkg::FSR_BIT_I_LOW, fsr_pkg::FSR_BIT_OVERTEMP,
                  fsr_pkg::FSR_BIT_WARM, fsr_pkg::FSR_BIT_V_LOW, fsr_pkg::FSR_BIT_V_WARN};
    logic ae[6] = '{1, 1, 1, 0, 1, 0};
    logic hy[6] = '{0, 0, 1, 1, 0, 0};
    for (int i = 0; i < 6; i++)
    begin
      comp = fsr_pkg::fsr_comp_t'(8'h01 << cb[i]);
      step(3);
      chk(fsw, 16'h0001 << sb[i]);
      chk(alert, ae[i]);
      comp = '0;
      step(3);
      chk(fsw[sb[i]], hy[i]);
      comp = fsr_pkg::fsr_comp_t'(hy[i] ? 8'h01 << (cb[i] - 1) : 8'h00);
      step(3);
      chk(fsw, 16'h0000);
      comp = '0;
    end
  endtask

  // ADC low byte source selection
  task automatic t_adc();
    for (int i = 1; i >= 0; i--)
    begin
      sel_temp = i[0];
      adc_done = 1'b1;
      step(1);
      adc_done = 1'b0;
      step(3);
      chk(fsw[7:0], i ? 8'hA5 : 8'h5A);
    end
    chk(i_host.code_volts(8'h00) == 0.0 && i_host.code_degc(8'h00) == 312.0, 1'b1);
    chk(i_host.code_volts(8'hFF) > 2.48 && i_host.code_volts(8'hFF) < 2.5, 1'b1);
    chk(i_host.code_degc(8'hFF) > -86.5 && i_host.code_degc(8'hFF) < -85.5, 1'b1);
  endtask

  // Packet error, readback and suppression
  task automatic t_frames();
    i_host.do_frame(1'b1, w, n);
    step(3);
    chk(fsw, 16'h405A);
    chk(alert, 1'b1);
    i_host.do_frame(1'b0, w, n);
    chk(w, 16'h405A);
    chk(n[15:0], 16'h0010);
    step(3);
    chk(fsw, 16'h005A);
    suppress = 1'b1;
    i_host.do_frame(1'b0, w, n);
    chk(n[15:0], 16'h0000);
    suppress = 1'b0;
  endtask

  // Link loss, alarm forcing and direction
  task automatic t_link();
    int k;
    wd_en = 1'b1;
    i_host.do_frame(1'b0, w, n);
    for (k = 0; k < 60 && fsw[15] !== 1'b1; k++)
      step(1);
    chk(k > 30 && k < 60, 1'b1);
    step(2);
    chk({fsw[15], alert, force_o, up_o}, 4'hF);
    dir_up = 1'b0;
    step(3);
    chk({force_o, up_o}, 2'b10);
    afd = 1'b1;
    step(3);
    chk({fsw[15], alert, force_o}, 3'b110);
    wd_en = 1'b0;
    step(3);
    chk({fsw[15], alert}, 2'b00);
  endtask

  // Clock enable low freezes flags and alert
  task automatic t_ce();
    ce = 1'b0;
    comp = fsr_pkg::fsr_comp_t'(8'h80);
    step(4);
    chk(fsw, 16'h005A);
    chk(alert, 1'b0);
    ce = 1'b1;
    step(3);
    chk(fsw, 16'h205A);
    chk(alert, 1'b1);
    comp = '0;
    step(3);
  endtask

  // Main sequence
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    {afd, sel_temp, suppress, wd_en, adc_done} = 5'h00;
    tmo = 8'h1E;
    comp = '0;
    s_code = 8'h5A;
    t_code = 8'hA5;
    dir_up = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    chk(fsw, 16'h0000);
    chk({alert, force_o, up_o, sdo_oe}, 4'h0);
    step(1);
    t_flags();
    t_adc();
    t_frames();
    t_link();
    t_ce();
    finish_test();
  end

  // Watchdog against a hang
  initial
  begin
    #(3000 * 50);
    n_fail++;
    finish_test();
  end
endmodule

// ==== hw/fsr_fault_status.sv ====
`timescale 1ns/1ps

// Operation
// (R1) Word: link15, packet14, current high13, low12, temp11, warm10, volt9, warn8, ADC7..0.
// (R2) Register is read-only; host writes never change its flags or ADC field.
// (R3) Link idle longer than programmed timeout sets bit 15 and fault alert.
// (R4) Link loss forces alarm current only while control bit 10 is zero.
// (R5) Forced alarm direction follows the alarm polarity select pin.
// (R6) CRC error on an incoming frame sets bit 14 and fault alert.
// (R7) Loop current above programmed value sets bit 13 and fault alert.
// (R8) Loop current below programmed value sets bit 12 and fault alert.
// (R9) Overtemperature set above 140C, cleared below 125C, drives fault alert.
// (R10) Warm flag set above 100C, cleared below 85C, no fault alert.
// (R11) Loop sense below 0.3 V sets bit 9 and fault alert.
// (R12) Loop sense below 0.6 V sets bit 8, no fault alert.
// (R13) Low byte holds ADC result, voltage or temperature per control bit 8.
// (R14) Host scales voltage code by 2.5/256 V; code zero is 0 V.
// (R15) Host converts temperature code as 312 minus 1.559 times code.
// (R16) Word shifts out on serial output each write unless readback suppressed.
// (R17) Link loss always sets its flag and fault alert, whatever alarm setting.
module fsr_fault_status #(
  parameter int WD_W = 24
) (
  // Clock, reset, clock enable
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Control register bits
  input  wire logic                 alarm_force_disable,
  input  wire logic                 adc_select_temp,
  input  wire logic                 readback_suppress,
  input  wire logic                 watchdog_enable,
  input  wire logic [WD_W-1:0]      timeout_cycles,
  // Serial frame events
  input  wire logic                 frame_start,
  input  wire logic                 shift_tick,
  input  wire logic                 frame_valid,
  input  wire logic                 crc_error,
  // Analog side
  input  wire fsr_pkg::fsr_comp_t   comp,
  input  wire logic                 adc_done,
  input  wire logic [7:0]           adc_sense_code,
  input  wire logic [7:0]           adc_temp_code,
  input  wire logic                 alarm_dir_up,
  // Outputs
  output fsr_pkg::fsr_status_t      fault_status,
  output logic                      fault_alert,
  output logic                      alarm_force,
  output logic                      alarm_upscale,
  output logic                      sdo,
  output logic                      sdo_oe
);

  // ----------------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------------
  logic                 link_loss;
  logic                 pkt_err_r;
  logic                 i_high_r;
  logic                 i_low_r;
  logic                 v_low_r;
  logic                 v_warn_r;
  logic [7:0]           adc_r;
  logic [1:0]           hyst_flag;
  logic [1:0]           hyst_set;
  logic [1:0]           hyst_clr;
  logic [15:0]          shift_r;
  logic [4:0]           bits_left_r;
  fsr_pkg::fsr_status_t status_nxt;
  logic                 alert_nxt;

  // ----------------------------------------------------------------------
  // Link watchdog
  // ----------------------------------------------------------------------
  fsr_watchdog #(
    .CW             (WD_W)
  ) u_wd (
    .clk            (clk),
    .rst            (rst),
    .ce             (ce),
    .enable         (watchdog_enable),
    .timeout_cycles (timeout_cycles),
    .frame_valid    (frame_valid),
    .expired        (link_loss)
  );

  // ----------------------------------------------------------------------
  // Temperature flags with hysteresis: index 1 over, index 0 warm
  // ----------------------------------------------------------------------
  assign hyst_set = {comp.temp_above_140, comp.temp_above_100};
  assign hyst_clr = {comp.temp_below_125, comp.temp_below_85};

  genvar gi;
  generate
    for (gi = 0; gi < fsr_pkg::FSR_HYST_FLAGS; gi++)
    begin : g_hyst
      fsr_hyst u_hyst (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .above_set   (hyst_set[gi]),
        .below_clear (hyst_clr[gi]),
        .flag        (hyst_flag[gi])  // [R9] [R10]
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Packet check flag: set by CRC error, cleared by a good frame
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pkt_err_r <= 1'b0;
    else if (ce)
    begin
      if (crc_error)
        pkt_err_r <= 1'b1;         // Set wins over clear [R6]
      else if (frame_valid)
        pkt_err_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Loop current and loop sense comparator flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      i_high_r <= 1'b0;
      i_low_r  <= 1'b0;
      v_low_r  <= 1'b0;
      v_warn_r <= 1'b0;
    end
    else if (ce)
    begin
      i_high_r <= comp.loop_current_over;   // [R7]
      i_low_r  <= comp.loop_current_under;  // [R8]
      v_low_r  <= comp.sense_below_0p3;     // [R11]
      v_warn_r <= comp.sense_below_0p6;     // [R12]
    end
  end

  // ----------------------------------------------------------------------
  // ADC result capture, source chosen by control bit
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      adc_r <= fsr_pkg::FSR_ADC_RESET;
    else if (ce && adc_done)
      adc_r <= adc_select_temp ? adc_temp_code : adc_sense_code; // [R13]
  end

  // ----------------------------------------------------------------------
  // Status word and alert assembly
  // ----------------------------------------------------------------------
  always_comb
  begin
    status_nxt.link_loss               = link_loss;    // [R3] [R17]
    status_nxt.packet_check_error_flag = pkt_err_r;
    status_nxt.loop_current_high_flag  = i_high_r;
    status_nxt.loop_current_low_flag   = i_low_r;
    status_nxt.overtemp                = hyst_flag[1];
    status_nxt.warm                    = hyst_flag[0];
    status_nxt.loop_voltage_low_flag   = v_low_r;
    status_nxt.loop_voltage_warn_flag  = v_warn_r;
    status_nxt.adc_value               = adc_r;        // [R1]
    // Warm and warn flags are left out of the alert [R10] [R12]
    alert_nxt = link_loss | pkt_err_r | i_high_r | i_low_r
              | hyst_flag[1] | v_low_r;                // [R3] [R6] [R11] [R17]
  end

  // ----------------------------------------------------------------------
  // Read-only register: only hardware state loads it, no write port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_status <= fsr_pkg::FSR_STATUS_RESET;
      fault_alert  <= 1'b0;
    end
    else if (ce)
    begin
      fault_status <= status_nxt;  // [R2]
      fault_alert  <= alert_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Alarm current control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_force   <= 1'b0;
      alarm_upscale <= 1'b0;
    end
    else if (ce)
    begin
      alarm_force   <= link_loss & ~alarm_force_disable;              // [R4]
      alarm_upscale <= link_loss & ~alarm_force_disable & alarm_dir_up; // [R5]
    end
  end

  // ----------------------------------------------------------------------
  // Readback shifter: word loaded at frame start, MSB first
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r     <= fsr_pkg::FSR_STATUS_RESET;
      bits_left_r <= '0;
    end
    else if (ce)
    begin
      if (frame_start && !readback_suppress)
      begin
        shift_r     <= fault_status;  // [R16]
        bits_left_r <= fsr_pkg::FSR_FRAME_BITS;
      end
      else if (frame_start)
        bits_left_r <= '0;
      else if (shift_tick && bits_left_r != 5'h00)
      begin
        shift_r     <= {shift_r[14:0], 1'b0};
        bits_left_r <= bits_left_r - 5'h01;
      end
    end
  end

  assign sdo    = shift_r[15];
  assign sdo_oe = (bits_left_r != 5'h00);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_load;
    ce && frame_start && !readback_suppress;
  endsequence

  sequence s_loaded;
    ##1 sdo_oe && bits_left_r == 5'h10;
  endsequence

  a_readback_load: assert property (@(posedge clk) disable iff (rst) // [R16]
    s_load |-> s_loaded ##0 (shift_r == $past(fault_status)))
    else $error("readback word not loaded at frame start");

  a_readback_quiet: assert property (@(posedge clk) disable iff (rst) // [R16]
    (ce && frame_start && readback_suppress) |=> !sdo_oe)
    else $error("serial output driven while readback suppressed");

  a_status_layout: assert property (@(posedge clk) disable iff (rst) // [R1]
    ce |=> fault_status[15] == $past(link_loss) && fault_status[7:0] == $past(adc_r))
    else $error("status word layout wrong");

  a_status_readonly: assert property (@(posedge clk) disable iff (rst) // [R2]
    !ce |=> $stable(fault_status))
    else $error("status changed without hardware update");

  a_link_alert: assert property (@(posedge clk) disable iff (rst) // [R3] [R17]
    (ce && link_loss) |=> fault_alert && fault_status.link_loss)
    else $error("link loss did not raise alert");

  a_alarm_gate: assert property (@(posedge clk) disable iff (rst) // [R4]
    (ce && link_loss && alarm_force_disable) |=> !alarm_force)
    else $error("alarm forced while disabled");

  a_alarm_dir: assert property (@(posedge clk) disable iff (rst) // [R5]
    (ce && link_loss && !alarm_force_disable) |=> alarm_force
      && alarm_upscale == $past(alarm_dir_up))
    else $error("alarm direction wrong");

  a_pkt_err_set: assert property (@(posedge clk) disable iff (rst) // [R6]
    (ce && crc_error) |=> pkt_err_r ##1 (!$past(ce) || fault_alert))
    else $error("crc error lost");

  a_warm_noalert: assert property (@(posedge clk) disable iff (rst) // [R10] [R12]
    (ce && !alert_nxt && (hyst_flag[0] || v_warn_r)) |=> !fault_alert)
    else $error("warning flag raised alert");

  a_adc_select: assert property (@(posedge clk) disable iff (rst) // [R13]
    (ce && adc_done && adc_select_temp) |=> adc_r == $past(adc_temp_code))
    else $error("adc source not selected");

  a_level_flags: assert property (@(posedge clk) disable iff (rst) // [R7] [R8] [R11]
    ce |=> i_high_r == $past(comp.loop_current_over)
      && i_low_r == $past(comp.loop_current_under)
      && v_low_r == $past(comp.sense_below_0p3))
    else $error("comparator flag did not follow its level");

  a_overtemp_hold: assert property (@(posedge clk) disable iff (rst) // [R9]
    (ce && hyst_flag[1] && !comp.temp_below_125) |=> hyst_flag[1])
    else $error("overtemperature flag cleared above lower threshold");

  a_fault_alert_set: assert property (@(posedge clk) disable iff (rst) // [R7] [R8] [R9] [R11]
    (ce && (i_high_r || i_low_r || hyst_flag[1] || v_low_r)) |=> fault_alert)
    else $error("fault flag did not raise alert");

endmodule

// ==== hw/fsr_hyst.sv ====
`timescale 1ns/1ps

// Flag with separate set and clear thresholds
module fsr_hyst (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Comparator levels
  input  wire logic above_set,
  input  wire logic below_clear,
  // Flag
  output logic      flag
);

  // ----------------------------------------------------------------------
  // Set above the upper threshold, clear only below the lower one
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag <= 1'b0;
    else if (ce)
    begin
      if (above_set)
        flag <= 1'b1;
      else if (below_clear)
        flag <= 1'b0;
    end
  end

endmodule

// ==== hw/fsr_watchdog.sv ====
`timescale 1ns/1ps

// Link watchdog: counts idle cycles since the last valid frame
module fsr_watchdog #(
  parameter int CW = 24
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  // Control
  input  wire logic          enable,
  input  wire logic [CW-1:0] timeout_cycles,
  input  wire logic          frame_valid,
  // Status
  output logic               expired
);

  logic [CW-1:0] count_r;

  // ----------------------------------------------------------------------
  // Idle counter, restarted by every valid frame
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= '0;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      if (!enable || frame_valid)
      begin
        count_r <= '0;
        expired <= 1'b0;
      end
      else if (count_r > timeout_cycles)
        expired <= 1'b1; // Idle strictly longer than the timeout
      else
        count_r <= count_r + CW'(1);
    end
  end

endmodule

// ==== shared/fsr_pkg.sv ====
package fsr_pkg;

  // ----------------------------------------------------------------------
  // Fault status word layout, most significant field first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       link_loss;              // Bit 15
    logic       packet_check_error_flag; // Bit 14
    logic       loop_current_high_flag; // Bit 13
    logic       loop_current_low_flag;  // Bit 12
    logic       overtemp;               // Bit 11
    logic       warm;                   // Bit 10
    logic       loop_voltage_low_flag;  // Bit 9
    logic       loop_voltage_warn_flag; // Bit 8
    logic [7:0] adc_value;              // Bits 7..0
  } fsr_status_t;

  // Analog comparator levels gathered together
  typedef struct packed {
    logic loop_current_over;
    logic loop_current_under;
    logic temp_above_140;
    logic temp_below_125;
    logic temp_above_100;
    logic temp_below_85;
    logic sense_below_0p3;
    logic sense_below_0p6;
  } fsr_comp_t;

  // ----------------------------------------------------------------------
  // Field positions, reset value and frame length
  // ----------------------------------------------------------------------
  localparam int             FSR_BIT_LINK_LOSS  = 15;
  localparam int             FSR_BIT_PKT_ERR    = 14;
  localparam int             FSR_BIT_I_HIGH     = 13;
  localparam int             FSR_BIT_I_LOW      = 12;
  localparam int             FSR_BIT_OVERTEMP   = 11;
  localparam int             FSR_BIT_WARM       = 10;
  localparam int             FSR_BIT_V_LOW      = 9;
  localparam int             FSR_BIT_V_WARN     = 8;
  localparam int             FSR_ADC_MSB        = 7;
  localparam logic [15:0]    FSR_STATUS_RESET   = 16'h0000;
  localparam logic [7:0]     FSR_ADC_RESET      = 8'h00;
  localparam logic [4:0]     FSR_FRAME_BITS     = 5'h10;
  localparam int             FSR_HYST_FLAGS     = 2;

endpackage
